// ==== shared/rbs_regs.svh ====
// Register offsets, field positions, reset values and opcodes of the branch and bit-set executor.
`ifndef RBS_REGS_SVH
`define RBS_REGS_SVH
`define RBS_OPC_NEG_CLR     8'he7
`define RBS_OPC_OV_CLR      8'he5
`define RBS_OPC_ZERO_CLR    8'he1
`define RBS_OPC_ALWAYS      5'h1a
`define RBS_OPC_SETBIT      4'h8
`define RBS_INDEXED_MAX     8'h5f
`define RBS_ACCESS_SPLIT    8'h60
`define RBS_PC_STEP         16'h0002
`define RBS_REG_CTRL        8'h00
`define RBS_REG_BANK        8'h01
`define RBS_REG_PC_LO       8'h02
`define RBS_REG_PC_HI       8'h03
`define RBS_REG_STATUS      8'h04
`define RBS_REG_INSTR_LO    8'h05
`define RBS_REG_INSTR_HI    8'h06
`define RBS_REG_TAKEN_CNT   8'h07
`define RBS_CTRL_EXT_BIT    0
`define RBS_CTRL_RUN_BIT    1
`define RBS_ST_NOP_BIT      0
`define RBS_ST_TAKEN_BIT    1
`define RBS_ST_UNSUP_BIT    2
`define RBS_ST_N_BIT        3
`define RBS_ST_OV_BIT       4
`define RBS_ST_Z_BIT        5
`define RBS_CTRL_RST        8'h02
`define RBS_BANK_RST        8'h00
`define RBS_PC_RST          16'h0000
`endif

// ==== shared/rbs_pkg.sv ====
// Types shared by the branch and bit-set executor.
package rbs_pkg;
   typedef enum logic [1:0] {
      phase_q1,
      phase_q2,
      phase_q3,
      phase_q4
   } rbs_phase_t;
   typedef enum logic [2:0] {
      op_none,
      op_branch_negative_clear,
      op_branch_overflow_clear,
      op_branch_zero_clear,
      op_branch_always,
      op_set_file_bit
   } rbs_op_t;
endpackage

// ==== shared/rbs_mem_if.sv ====
// Port bundle between the executor and its data-memory array.
`timescale 1ns/10ps
`default_nettype none
interface rbs_mem_if #(parameter int AW = 12);
   logic [AW-1:0] addr;
   logic          rd_en;
   logic          wr_en;
   logic [7:0]    wdata;
   logic [7:0]    rdata;
   modport ctrl (output addr, output rd_en, output wr_en, output wdata, input rdata);
   modport mem  (input addr, input rd_en, input wr_en, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== hdl/rbs_seq.sv ====
// Four-phase instruction-cycle sequencer.
`timescale 1ns/10ps
`default_nettype none
module rbs_seq
   import rbs_pkg::*;
(
   input  wire logic     clk_in,
   input  wire logic     resetn_in,
   output var  rbs_phase_t phase_out
);
   rbs_phase_t phase_r;
   rbs_phase_t phase_nxt;

   always_comb begin
      case (phase_r)
         phase_q1: phase_nxt = phase_q2;
         phase_q2: phase_nxt = phase_q3;
         phase_q3: phase_nxt = phase_q4;
         phase_q4: phase_nxt = phase_q1;
         default:  phase_nxt = phase_q1;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_r <= phase_q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase_out = phase_r;
endmodule
`default_nettype wire

// ==== hdl/rbs_file_mem.sv ====
// Banked data-memory array with registered read data.
`timescale 1ns/10ps
`default_nettype none
module rbs_file_mem #(
   parameter int AW = 12
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   rbs_mem_if.mem    bus
);
   logic [7:0] mem_r [2**AW];
   logic [7:0] rdata_r;

   // The array has no reset, so it maps onto plain block memory.
   always_ff @(posedge clk_in) begin
      if (bus.wr_en) begin
         mem_r[bus.addr] <= bus.wdata;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_r <= 8'h00;
      end else if (bus.rd_en) begin
         rdata_r <= mem_r[bus.addr];
      end
   end

   assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// ==== hdl/rbs_exec.sv ====
// Relative branch and file bit-set executor on a four-phase instruction cycle.
//
// Contract
// - Taken branch loads PC with incremented PC plus twice the signed offset.
// - Conditional branch is one word, one cycle untaken, two cycles taken.
// - Taken branch writes PC in first cycle; second cycle is a no-operation.
// - Opcode e5 with offset branches only when Overflow is clear.
// - Opcode e1 with offset branches only when Zero is clear.
// - Opcode e7 with offset branches only when Negative is clear.
// - Conditional branch offset is the low byte, signed -128 to 127.
// - Top bits 11010 branch always with signed eleven-bit offset.
// - Always-branch takes two cycles, second one a no-operation.
// - Bit-set forces selected bit of addressed register, others unchanged.
// - Access flag zero addresses the access bank.
// - Access flag one uses the bank select register to choose the bank.
// - Extended set, access flag zero, address up to 5f uses indexed addressing.
`timescale 1ns/10ps
`default_nettype none
`include "rbs_regs.svh"
module rbs_exec
   import rbs_pkg::*;
#(
   parameter int PC_W   = 16,
   parameter int BANK_W = 4
) (
   input  wire logic                clk_in,
   input  wire logic                resetn_in,
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic [7:0]          reg_wdata_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   output logic      [7:0]          reg_rdata_out,
   input  wire logic [15:0]         instr_in,
   input  wire logic                instr_valid_in,
   input  wire logic                flag_n_in,
   input  wire logic                flag_ov_in,
   input  wire logic                flag_z_in,
   input  wire logic [BANK_W+7:0]   fsr2_in,
   output logic      [PC_W-1:0]     pc_out,
   output logic                     pc_write_out,
   output logic                     nop_cycle_out,
   output logic                     instr_taken_out,
   output logic                     wr_strobe_out,
   output logic      [BANK_W+7:0]   wr_addr_out,
   output logic      [7:0]          wr_data_out,
   output logic                     unsupported_out
);
   localparam int DATA_AW = BANK_W + 8;

   if (PC_W < 13 || PC_W > 16) begin : g_pc_check
      $error("PC_W must lie between 13 and 16");
   end
   if (BANK_W < 1 || BANK_W > 8) begin : g_bank_check
      $error("BANK_W must lie between 1 and 8");
   end

   function automatic rbs_op_t decode_op(input logic [15:0] w);
      rbs_op_t op;
      op = op_none;
      if (w[15:8] == `RBS_OPC_NEG_CLR) begin
         op = op_branch_negative_clear;
      end else if (w[15:8] == `RBS_OPC_OV_CLR) begin
         op = op_branch_overflow_clear;
      end else if (w[15:8] == `RBS_OPC_ZERO_CLR) begin
         op = op_branch_zero_clear;
      end else if (w[15:11] == `RBS_OPC_ALWAYS) begin
         op = op_branch_always;
      end else if (w[15:12] == `RBS_OPC_SETBIT) begin
         op = op_set_file_bit;
      end
      return op;
   endfunction

   // The displacement is already doubled, so it adds straight onto the word-aligned PC.
   function automatic logic [PC_W-1:0] branch_disp(input rbs_op_t op, input logic [15:0] w);
      logic [PC_W-1:0] d;
      if (op == op_branch_always) begin
         d = {{(PC_W-12){w[10]}}, w[10:0], 1'b0};
      end else begin
         d = {{(PC_W-9){w[7]}}, w[7:0], 1'b0};
      end
      return d;
   endfunction

   function automatic logic [DATA_AW-1:0] file_addr(input logic [15:0] w, input logic ext,
                                                    input logic [BANK_W-1:0] bank,
                                                    input logic [DATA_AW-1:0] fsr2);
      logic [DATA_AW-1:0] a;
      if (w[8]) begin
         a = {bank, w[7:0]};
      end else if (ext && (w[7:0] <= `RBS_INDEXED_MAX)) begin
         a = fsr2 + {{BANK_W{1'b0}}, w[7:0]};
      end else if (w[7:0] < `RBS_ACCESS_SPLIT) begin
         a = {{BANK_W{1'b0}}, w[7:0]};
      end else begin
         a = {{BANK_W{1'b1}}, w[7:0]};
      end
      return a;
   endfunction

   rbs_phase_t phase;
   rbs_mem_if #(.AW(DATA_AW)) mem_bus ();

   rbs_seq u_seq (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .phase_out (phase)
   );

   rbs_file_mem #(.AW(DATA_AW)) u_mem (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .bus       (mem_bus.mem)
   );

   logic [7:0]         ctrl_r;
   logic [BANK_W-1:0]  bank_r;
   logic [PC_W-1:0]    pc_r;
   logic [15:0]        instr_r;
   rbs_op_t            op_r;
   logic               nop_r;
   logic               nop_pending_r;
   logic               taken_r;
   logic [DATA_AW-1:0] rmw_addr_r;
   logic [7:0]         mod_r;
   logic [2:0]         flags_r;
   logic [7:0]         taken_cnt_r;
   logic               unsup_r;
   logic               pc_write_r;
   logic               instr_taken_r;
   logic               wr_strobe_r;
   logic [DATA_AW-1:0] wr_addr_r;
   logic [7:0]         wr_data_r;
   logic [7:0]         rdata_r;

   wire logic is_q1 = (phase == phase_q1);
   wire logic is_q2 = (phase == phase_q2);
   wire logic is_q3 = (phase == phase_q3);
   wire logic is_q4 = (phase == phase_q4);
   wire logic run   = ctrl_r[`RBS_CTRL_RUN_BIT];
   wire logic ext   = ctrl_r[`RBS_CTRL_EXT_BIT];

   // A fetch is refused in the no-operation cycle that follows a taken branch.
   wire logic take_instr = is_q1 && run && !nop_pending_r && instr_valid_in;
   wire rbs_op_t op_nxt = take_instr ? decode_op(instr_in) : op_none;
   wire logic is_set_op = (op_r == op_set_file_bit);

   // Status flags are only read here; nothing in this block drives them.
   wire logic cond_met = ((op_r == op_branch_negative_clear) && !flag_n_in)
                      || ((op_r == op_branch_overflow_clear) && !flag_ov_in)
                      || ((op_r == op_branch_zero_clear) && !flag_z_in)
                      || (op_r == op_branch_always);

   wire logic [PC_W-1:0] pc_inc = pc_r + PC_W'(`RBS_PC_STEP);
   wire logic [PC_W-1:0] pc_target = pc_r + branch_disp(op_r, instr_r);
   wire logic [DATA_AW-1:0] rmw_addr_nxt = file_addr(instr_r, ext, bank_r, fsr2_in);
   wire logic [7:0] bit_mask = 8'h01 << instr_r[11:9];
   wire logic [7:0] mod_nxt = mem_bus.rdata | bit_mask;

   wire logic wr_ctrl   = reg_wr_in && (reg_addr_in == `RBS_REG_CTRL);
   wire logic wr_bank   = reg_wr_in && (reg_addr_in == `RBS_REG_BANK);
   wire logic wr_pc_lo  = reg_wr_in && (reg_addr_in == `RBS_REG_PC_LO) && !run;
   wire logic wr_pc_hi  = reg_wr_in && (reg_addr_in == `RBS_REG_PC_HI) && !run;
   wire logic wr_status = reg_wr_in && (reg_addr_in == `RBS_REG_STATUS);
   wire logic wr_cnt    = reg_wr_in && (reg_addr_in == `RBS_REG_TAKEN_CNT);
   wire logic [15:0] pc_wide = 16'(pc_r);
   wire logic [7:0] status_view = {2'b00, flags_r, unsup_r, taken_r, nop_r};
   wire logic [7:0] rd_sel =
      (reg_addr_in == `RBS_REG_CTRL)      ? ctrl_r :
      (reg_addr_in == `RBS_REG_BANK)      ? 8'(bank_r) :
      (reg_addr_in == `RBS_REG_PC_LO)     ? pc_wide[7:0] :
      (reg_addr_in == `RBS_REG_PC_HI)     ? pc_wide[15:8] :
      (reg_addr_in == `RBS_REG_STATUS)    ? status_view :
      (reg_addr_in == `RBS_REG_INSTR_LO)  ? instr_r[7:0] :
      (reg_addr_in == `RBS_REG_INSTR_HI)  ? instr_r[15:8] :
      (reg_addr_in == `RBS_REG_TAKEN_CNT) ? taken_cnt_r : 8'h00;

   // The one address line serves both accesses; they fall in different phases.
   assign mem_bus.rd_en = is_q2 && is_set_op;
   assign mem_bus.wr_en = is_q4 && is_set_op;
   assign mem_bus.addr  = is_q4 ? rmw_addr_r : rmw_addr_nxt;
   assign mem_bus.wdata = mod_r;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_r <= `RBS_CTRL_RST;
         bank_r <= BANK_W'(`RBS_BANK_RST);
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= {6'h00, reg_wdata_in[1:0]};
         end
         if (wr_bank) begin
            bank_r <= reg_wdata_in[BANK_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         instr_r <= 16'h0000;
         op_r    <= op_none;
      end else if (is_q1) begin
         op_r <= op_nxt;
         if (take_instr) begin
            instr_r <= instr_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pc_r <= PC_W'(`RBS_PC_RST);
      end else if (take_instr) begin
         pc_r <= pc_inc;
      end else if (is_q4 && taken_r) begin
         pc_r <= pc_target;
      end else if (wr_pc_lo) begin
         pc_r[7:0] <= reg_wdata_in;
      end else if (wr_pc_hi) begin
         pc_r[PC_W-1:8] <= reg_wdata_in[PC_W-9:0];
      end
   end

   // A taken branch books one extra instruction cycle that executes nothing.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         taken_r       <= 1'b0;
         nop_pending_r <= 1'b0;
         nop_r         <= 1'b0;
      end else begin
         if (is_q3) begin
            taken_r <= cond_met;
         end else if (is_q1) begin
            taken_r <= 1'b0;
         end
         if (is_q4 && taken_r) begin
            nop_pending_r <= 1'b1;
         end else if (is_q1) begin
            nop_pending_r <= 1'b0;
         end
         if (is_q1) begin
            nop_r <= nop_pending_r;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rmw_addr_r <= '0;
         mod_r      <= 8'h00;
         flags_r    <= 3'b000;
      end else begin
         if (is_q2) begin
            rmw_addr_r <= rmw_addr_nxt;
         end
         if (is_q3) begin
            mod_r   <= mod_nxt;
            flags_r <= {flag_z_in, flag_ov_in, flag_n_in};
         end
      end
   end

   // A clear by software in the same cycle as a new event leaves the bit set.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         unsup_r     <= 1'b0;
         taken_cnt_r <= 8'h00;
      end else begin
         // Only a word accepted in this instruction cycle counts, so a stale word never re-flags.
         if (is_q2 && instr_taken_r && (op_r == op_none) && (instr_r != 16'h0000)) begin
            unsup_r <= 1'b1;
         end else if (wr_status && reg_wdata_in[`RBS_ST_UNSUP_BIT]) begin
            unsup_r <= 1'b0;
         end
         if (is_q4 && taken_r) begin
            taken_cnt_r <= wr_cnt ? 8'h01 : taken_cnt_r + 8'h01;
         end else if (wr_cnt) begin
            taken_cnt_r <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pc_write_r    <= 1'b0;
         instr_taken_r <= 1'b0;
         wr_strobe_r   <= 1'b0;
         wr_addr_r     <= '0;
         wr_data_r     <= 8'h00;
      end else begin
         pc_write_r    <= is_q4 && taken_r;
         instr_taken_r <= take_instr;
         wr_strobe_r   <= mem_bus.wr_en;
         if (mem_bus.wr_en) begin
            wr_addr_r <= rmw_addr_r;
            wr_data_r <= mod_r;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= reg_rd_in ? rd_sel : 8'h00;
      end
   end

   assign reg_rdata_out   = rdata_r;
   assign pc_out          = pc_r;
   assign pc_write_out    = pc_write_r;
   assign nop_cycle_out   = nop_r;
   assign instr_taken_out = instr_taken_r;
   assign wr_strobe_out   = wr_strobe_r;
   assign wr_addr_out     = wr_addr_r;
   assign wr_data_out     = wr_data_r;
   assign unsupported_out = unsup_r;
endmodule
`default_nettype wire

// ==== test/rbs_prog_model.sv ====
// Program-memory model that answers each fetch address with an instruction word.
`timescale 1ns/10ps
`default_nettype none
module rbs_prog_model (
   input  wire logic [15:0] pc_in,
   output logic      [15:0] word_out
);
   // Sixteen words alias across the space, so the bench keeps a word valid for one fetch only.
   logic [15:0] mem [16];
   initial begin
      foreach (mem[i]) begin
         mem[i] = 16'h0000;
      end
   end
   assign word_out = mem[pc_in[4:1]];
endmodule
`default_nettype wire

// ==== test/rbs_exec_monitor.sv ====
// Port checker for the branch and bit-set executor.
`timescale 1ns/10ps
`default_nettype none
`include "rbs_regs.svh"
module rbs_exec_monitor #(
   parameter int PC_W   = 16,
   parameter int BANK_W = 4
) (
   input wire logic              clk_in,
   input wire logic              resetn_in,
   input wire logic [7:0]        reg_addr_in,
   input wire logic [7:0]        reg_wdata_in,
   input wire logic              reg_wr_in,
   input wire logic              reg_rd_in,
   input wire logic [7:0]        reg_rdata_out,
   input wire logic [15:0]       instr_in,
   input wire logic              instr_valid_in,
   input wire logic              flag_n_in,
   input wire logic              flag_ov_in,
   input wire logic              flag_z_in,
   input wire logic [BANK_W+7:0] fsr2_in,
   input wire logic [PC_W-1:0]   pc_out,
   input wire logic              pc_write_out,
   input wire logic              nop_cycle_out,
   input wire logic              instr_taken_out,
   input wire logic              wr_strobe_out,
   input wire logic [BANK_W+7:0] wr_addr_out,
   input wire logic [7:0]        wr_data_out,
   input wire logic              unsupported_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // The accepted word is one clock old when the accept pulse shows.
   sequence took_setbit_s;
      instr_taken_out && $past(instr_in[15:12]) == `RBS_OPC_SETBIT;
   endsequence
   sequence took_always_s;
      instr_taken_out && $past(instr_in[15:11]) == `RBS_OPC_ALWAYS;
   endsequence
   accept_spacing_a: assert property (instr_taken_out |=> !instr_taken_out [*3])
      else $error("two words accepted in one cycle");
   nop_length_a: assert property ($rose(nop_cycle_out) |-> nop_cycle_out [*4] ##1 !nop_cycle_out)
      else $error("no-op cycle length wrong");
   nop_idle_a: assert property (nop_cycle_out |-> !instr_taken_out && !wr_strobe_out)
      else $error("work done in no-op cycle");
   pc_step_a: assert property (instr_taken_out |-> pc_out == PC_W'($past(pc_out) + 2))
      else $error("pc not advanced by one word");
   always_branch_a: assert property (took_always_s |-> ##3 pc_write_out ##1 nop_cycle_out [*4])
      else $error("unconditional branch not taken");
   setbit_write_a: assert property (took_setbit_s |-> ##3 wr_strobe_out && !pc_write_out
      && wr_data_out[$past(instr_in[11:9], 4)])
      else $error("bit-set write wrong");
   write_pulse_a: assert property (wr_strobe_out |=> !wr_strobe_out)
      else $error("write strobe too long");
   bank_addr_a: assert property (took_setbit_s ##0 $past(instr_in[8])
      |-> ##3 wr_addr_out[7:0] == $past(instr_in[7:0], 4))
      else $error("banked address low byte wrong");
   access_addr_a: assert property (took_setbit_s ##0 (!$past(instr_in[8])
      && $past(instr_in[7:0]) >= `RBS_ACCESS_SPLIT)
      |-> ##3 wr_addr_out == {{BANK_W{1'b1}}, $past(instr_in[7:0], 4)})
      else $error("access bank upper address wrong");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the branch and bit-set executor.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int PC_W   = 16;
   localparam int BANK_W = 4;
   typedef struct packed {
      logic [15:0] word;
      logic [2:0]  flags;
      logic        ext;
      logic [15:0] exp;
   } rbs_row_t;
   logic              clk_in;
   logic              resetn_in;
   logic [7:0]        reg_addr_in;
   logic [7:0]        reg_wdata_in;
   logic              reg_wr_in;
   logic              reg_rd_in;
   logic [7:0]        reg_rdata_out;
   logic [15:0]       instr_in;
   logic              instr_valid_in;
   logic              flag_n_in;
   logic              flag_ov_in;
   logic              flag_z_in;
   logic [BANK_W+7:0] fsr2_in;
   logic [PC_W-1:0]   pc_out;
   logic              pc_write_out;
   logic              nop_cycle_out;
   logic              instr_taken_out;
   logic              wr_strobe_out;
   logic [BANK_W+7:0] wr_addr_out;
   logic [7:0]        wr_data_out;
   logic              unsupported_out;
   logic              saw_nop;
   logic              saw_wr;
   logic [7:0]        rd_val;
   int                mismatches;
   int                checks_done;
   // Branch rows give the pc offset from 0x0100; bit-set rows the address written.
   rbs_row_t rows [15] = '{
      '{16'he57f, 3'b101, 1'b0, 16'h0100}, '{16'he57f, 3'b010, 1'b0, 16'h0002},
      '{16'he180, 3'b110, 1'b0, 16'hff02}, '{16'he180, 3'b001, 1'b0, 16'h0002},
      '{16'he701, 3'b011, 1'b0, 16'h0004}, '{16'he701, 3'b100, 1'b0, 16'h0002},
      '{16'hd3ff, 3'b111, 1'b0, 16'h0800}, '{16'hd400, 3'b000, 1'b0, 16'hf802},
      '{16'h8725, 3'b000, 1'b0, 16'h0325}, '{16'h8a25, 3'b000, 1'b0, 16'h0025},
      '{16'h8080, 3'b000, 1'b0, 16'h0f80}, '{16'h8e10, 3'b000, 1'b1, 16'h0210},
      '{16'h8260, 3'b000, 1'b1, 16'h0f60}, '{16'h8a25, 3'b000, 1'b1, 16'h0225},
      '{16'h8e10, 3'b000, 1'b0, 16'h0010}
   };
   rbs_exec #(.PC_W(PC_W), .BANK_W(BANK_W)) u_rbs_exec (.*);
   rbs_prog_model u_rbs_prog_model (.pc_in(pc_out), .word_out(instr_in));
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      d = reg_rdata_out;
   endtask
   // Halting first lets the pc be loaded; the word is offered until one accept is seen.
   task automatic run_word(input logic [15:0] w, input logic [2:0] fl, input logic ext);
      int n;
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h03, 8'h01);
      u_rbs_prog_model.mem[0] = w;
      {flag_n_in, flag_ov_in, flag_z_in} <= fl;
      saw_nop = 1'b0;
      saw_wr = 1'b0;
      wr(8'h00, {6'h00, 1'b1, ext});
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      n = 0;
      @(negedge clk_in);
      while (instr_taken_out !== 1'b1 && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      check("accepted", 16'(instr_taken_out), 16'h0001);
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask
   always @(posedge clk_in) begin
      if (nop_cycle_out === 1'b1) begin
         saw_nop <= 1'b1;
      end
      if (wr_strobe_out === 1'b1) begin
         saw_wr <= 1'b1;
      end
   end
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      mismatches++;
      end_of_test();
   end
   initial begin
      resetn_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      instr_valid_in = 1'b0;
      {flag_n_in, flag_ov_in, flag_z_in} = 3'b000;
      fsr2_in = 12'h200;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(8'h00, rd_val);
      check("ctrl", {8'h00, rd_val}, 16'h0002);
      rd(8'h20, rd_val);
      check("unmapped", {8'h00, rd_val}, 16'h0000);
      wr(8'h01, 8'h03);
      foreach (rows[i]) begin
         run_word(rows[i].word, rows[i].flags, rows[i].ext);
         if (rows[i].word[15:12] == 4'h8) begin
            check("wr_addr", {4'h0, wr_addr_out}, rows[i].exp);
            check("wr_bit", 16'(wr_data_out[rows[i].word[11:9]]), 16'h0001);
            check("wr_seen", 16'(saw_wr), 16'h0001);
         end else begin
            check("pc", pc_out, 16'h0100 + rows[i].exp);
            check("nop", 16'(saw_nop), 16'(rows[i].exp != 16'h0002));
         end
      end
      rd(8'h07, rd_val);
      check("taken_cnt", {8'h00, rd_val}, 16'h0005);
      for (int b = 0; b < 8; b++) begin
         run_word({4'h8, 3'(b), 9'h144}, 3'b000, 1'b0);
         check("set_bit", 16'(wr_data_out[b]), 16'h0001);
      end
      check("full_byte", {8'h00, wr_data_out}, 16'h00ff);
      run_word(16'he205, 3'b000, 1'b0);
      check("unsup", 16'(unsupported_out), 16'h0001);
      check("pc_plain", pc_out, 16'h0102);
      wr(8'h02, 8'h55);
      rd(8'h02, rd_val);
      check("pc_locked", {8'h00, rd_val}, 16'h0002);
      wr(8'h04, 8'h04);
      repeat (2) @(posedge clk_in);
      check("unsup_clr", 16'(unsupported_out), 16'h0000);
      wr(8'h00, 8'h00);
      instr_valid_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      instr_valid_in <= 1'b0;
      check("pc_halted", pc_out, 16'h0102);
      // A reset late in the test, while halted with bank 3 selected, must restore pc, control and bank.
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check("pc_reset", pc_out, 16'h0000);
      resetn_in <= 1'b1;
      rd(8'h00, rd_val);
      check("ctrl_reset", {8'h00, rd_val}, 16'h0002);
      rd(8'h01, rd_val);
      check("bank_reset", {8'h00, rd_val}, 16'h0000);
      end_of_test();
   end
endmodule
bind rbs_exec rbs_exec_monitor #(.PC_W(PC_W), .BANK_W(BANK_W)) u_rbs_exec_monitor (.*);
`default_nettype wire
